// ===== exec_pkg.sv
// Shared constants and types for the instruction execution subset
package exec_pkg;
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int EXT_W = 56;
  localparam int PM_W = 24;
  localparam int LIT_W = 10;
  localparam int PAGE_W = 8;
  localparam int SHAMT_W = 6;
  // Latency of the two operation classes in core clock cycles
  localparam int ALU_CYCLES = 1;
  localparam int TABLE_CYCLES = 2;
  // Accumulator rounding bias and saturation limits
  localparam logic [EXT_W-1:0] ROUND_BIAS = 56'h00000000008000;
  localparam logic [ACC_W-1:0] SAT_POS = 40'h007FFFFFFF;
  localparam logic [ACC_W-1:0] SAT_NEG = 40'hFF80000000;
  // Overflow guard bits of the accumulator: 39 down to 31
  localparam int OVF_LSB = 31;
  localparam int STORE_LSB = 16;
  // Status flag values after reset
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [3:0] {
    rotate_right_nocarry_op,
    accum_store_op,
    accum_store_rounded_op,
    sign_extend_op,
    accum_arith_shift_op,
    left_shift_op,
    left_shift_multi_op,
    sub_with_borrow_op,
    rev_sub_with_borrow_op,
    table_read_high_op,
    table_read_low_op,
    table_write_high_op,
    table_write_low_op,
    zero_extend_op
  } op_t;

  typedef enum logic {
    ST_IDLE,
    ST_TABLE
  } state_t;
endpackage

// ===== acc_shift_if.sv
// Carrier between the execution unit and its accumulator shifter
`timescale 1ns/1ps
interface acc_shift_if;
  import exec_pkg::*;
  logic [ACC_W-1:0] acc_in;
  logic [SHAMT_W-1:0] shamt;
  logic round;
  logic sat_en;
  logic [ACC_W-1:0] acc_out;
  logic [DATA_W-1:0] store_word;
  logic ovf;
  logic sat;
  modport core (output acc_in, shamt, round, sat_en,
                input acc_out, store_word, ovf, sat);
  modport shifter (input acc_in, shamt, round, sat_en,
                   output acc_out, store_word, ovf, sat);
endinterface

// ===== acc_shifter.sv
// Accumulator arithmetic shifter with rounding and saturation
`timescale 1ns/1ps
module acc_shifter (
  // Operands and results
  acc_shift_if.shifter sh
);
  import exec_pkg::*;
  logic signed [EXT_W-1:0] ext_w;
  logic signed [EXT_W-1:0] wide_w;
  logic [EXT_W-1:0] rnd_w;
  logic [SHAMT_W-1:0] mag_w;
  logic [ACC_W-OVF_LSB-1:0] guard_w;

  // Positive amounts shift right, negative ones shift left
  always_comb begin
    ext_w = {{(EXT_W-ACC_W){sh.acc_in[ACC_W-1]}}, sh.acc_in};
    mag_w = sh.shamt[SHAMT_W-1] ? SHAMT_W'(-sh.shamt) : sh.shamt;
    if (sh.shamt[SHAMT_W-1]) begin
      wide_w = ext_w <<< mag_w;
    end else begin
      wide_w = ext_w >>> mag_w;
    end
    rnd_w = sh.round ? wide_w + ROUND_BIAS : wide_w;
    guard_w = wide_w[ACC_W-1:OVF_LSB];
    sh.store_word = rnd_w[STORE_LSB+DATA_W-1:STORE_LSB];
    // Overflow means the guard bits no longer agree with the sign
    sh.ovf = !((&guard_w) || !(|guard_w));
    sh.sat = sh.sat_en && sh.ovf;
    if (sh.sat) begin
      // Clamp on the true sign kept in the extended result
      sh.acc_out = wide_w[EXT_W-1] ? SAT_NEG : SAT_POS;
    end else begin
      sh.acc_out = wide_w[ACC_W-1:0];
    end
  end
endmodule

// ===== instr_exec_subset.sv
// Execution unit for rotate, shift, extend, borrow-subtract and table ops
`timescale 1ns/1ps
//
// Overview of operation
// - Rotate right without carry, one cycle, only N and Z change
// - Store accumulator after signed 4-bit shift, optional rounding, no flags
// - Sign extend source byte in one cycle, updating C, N and Z
// - Shift accumulator by register or signed 6-bit literal, set OA/SA (acc A) or OB/SB (acc B) flags
// - Single left shift sets C,N,OV,Z; multi-bit shifts set only N,Z
// - Subtract with borrow: a minus b minus inverted carry, sets C,DC,N,OV,Z
// - Reverse subtract with borrow: b minus a minus inverted carry, same flags
// - Table read high loads memory bits 23:16 into destination low byte
// - Table read low loads memory bits 15:0 into destination, two cycles
// - Table write high stores source low byte into memory bits 23:16
// - Table write low stores whole source word into memory bits 15:0
// - Zero extend source byte in one cycle, updating C, Z and N
module instr_exec_subset (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire exec_pkg::op_t op_code,
  input wire logic [exec_pkg::DATA_W-1:0] opnd_a,
  input wire logic [exec_pkg::DATA_W-1:0] opnd_b,
  input wire logic op_use_lit,
  input wire logic [exec_pkg::LIT_W-1:0] op_lit,
  input wire logic acc_sel,
  input wire logic [exec_pkg::ACC_W-1:0] acc_a,
  input wire logic [exec_pkg::ACC_W-1:0] acc_b,
  input wire logic sat_enable,
  input wire logic [exec_pkg::PAGE_W-1:0] tbl_page,
  // Results
  output logic op_done,
  output logic res_valid,
  output logic [exec_pkg::DATA_W-1:0] res_data,
  output logic acc_wr,
  output logic acc_wr_sel,
  output logic [exec_pkg::ACC_W-1:0] acc_res,
  // Program memory
  output logic [exec_pkg::PM_W-1:0] pm_addr,
  output logic pm_rd,
  output logic pm_wr_hi,
  output logic pm_wr_lo,
  output logic [exec_pkg::PM_W-1:0] pm_wdata,
  input wire logic [exec_pkg::PM_W-1:0] pm_rdata,
  // Status flags
  output logic flag_c,
  output logic digit_carry_flag,
  output logic flag_n,
  output logic signed_overflow_flag,
  output logic flag_z,
  output logic accum_a_overflow_flag,
  output logic accum_b_overflow_flag,
  output logic accum_any_overflow_flag,
  output logic accum_a_saturate_flag,
  output logic accum_b_saturate_flag,
  output logic accum_any_saturate_flag
);
  import exec_pkg::*;

  acc_shift_if sh ();
  acc_shifter u_shifter (.sh(sh));

  state_t state_r, state_nxt;
  op_t tbl_op_r, tbl_op_nxt;
  logic [PM_W-1:0] tbl_addr_r, tbl_addr_nxt;
  logic [PM_W-1:0] tbl_wdata_r, tbl_wdata_nxt;
  logic [DATA_W-1:0] res_data_r, res_data_nxt;
  logic res_valid_r, res_valid_nxt;
  logic done_r, done_nxt;
  logic acc_wr_r, acc_wr_nxt;
  logic acc_sel_r, acc_sel_nxt;
  logic [ACC_W-1:0] acc_res_r, acc_res_nxt;
  logic c_r, c_nxt, dc_r, dc_nxt, n_r, n_nxt, ov_r, ov_nxt, z_r, z_nxt;
  logic oa_r, oa_nxt, ob_r, ob_nxt, sa_r, sa_nxt, sb_r, sb_nxt;

  logic fire_w;
  logic [DATA_W-1:0] opb_w;
  logic [DATA_W-1:0] res_w;
  logic [DATA_W-1:0] mn_w, sb_w;
  logic [DATA_W:0] diff_w;
  logic [4:0] nib_w;
  logic tbl_read_w;

  assign fire_w = op_valid && op_ready;
  assign opb_w = op_use_lit ? {{(DATA_W-LIT_W){1'b0}}, op_lit} : opnd_b;
  assign op_ready = (state_r == ST_IDLE);

  // Shifter operands; the store form takes a 4-bit signed literal
  assign sh.acc_in = acc_sel ? acc_b : acc_a;
  assign sh.shamt = (op_code == accum_arith_shift_op) ? opb_w[SHAMT_W-1:0]
                    : {{2{op_lit[3]}}, op_lit[3:0]};
  assign sh.round = (op_code == accum_store_rounded_op);
  assign sh.sat_en = sat_enable;

  // Shared borrow subtractor, operands swapped for the reverse form
  always_comb begin
    if (op_code == rev_sub_with_borrow_op) begin
      mn_w = opb_w;
      sb_w = opnd_a;
    end else begin
      mn_w = opnd_a;
      sb_w = opb_w;
    end
    diff_w = {1'b0, mn_w} + {1'b0, ~sb_w} + {{DATA_W{1'b0}}, c_r};
    nib_w = {1'b0, mn_w[3:0]} + {1'b0, ~sb_w[3:0]} + {4'h0, c_r};
  end

  always_comb begin
    state_nxt = state_r;
    tbl_op_nxt = tbl_op_r;
    tbl_addr_nxt = tbl_addr_r;
    tbl_wdata_nxt = tbl_wdata_r;
    res_data_nxt = res_data_r;
    res_valid_nxt = 1'b0;
    done_nxt = 1'b0;
    acc_wr_nxt = 1'b0;
    acc_sel_nxt = acc_sel_r;
    acc_res_nxt = acc_res_r;
    // Every flag holds unless its operation names it
    c_nxt = c_r;
    dc_nxt = dc_r;
    n_nxt = n_r;
    ov_nxt = ov_r;
    z_nxt = z_r;
    oa_nxt = oa_r;
    ob_nxt = ob_r;
    sa_nxt = sa_r;
    sb_nxt = sb_r;
    res_w = res_data_r;
    case (state_r)
      ST_IDLE: begin
        if (fire_w) begin
          done_nxt = 1'b1;
          res_valid_nxt = 1'b1;
          case (op_code)
            rotate_right_nocarry_op: begin
              res_w = {opnd_a[0], opnd_a[DATA_W-1:1]};
              n_nxt = res_w[DATA_W-1];
              z_nxt = (res_w == '0);
            end
            accum_store_op, accum_store_rounded_op: begin
              res_w = sh.store_word;
            end
            sign_extend_op: begin
              res_w = {{8{opnd_a[7]}}, opnd_a[7:0]};
              c_nxt = ~res_w[DATA_W-1];
              n_nxt = res_w[DATA_W-1];
              z_nxt = (res_w == '0);
            end
            zero_extend_op: begin
              res_w = {8'h00, opnd_a[7:0]};
              c_nxt = 1'b1;
              n_nxt = 1'b0;
              z_nxt = (res_w == '0);
            end
            accum_arith_shift_op: begin
              res_valid_nxt = 1'b0;
              acc_wr_nxt = 1'b1;
              acc_sel_nxt = acc_sel;
              acc_res_nxt = sh.acc_out;
              // Saturation flags are sticky until reset clears them
              if (acc_sel) begin
                ob_nxt = sh.ovf;
                sb_nxt = sb_r | sh.sat;
              end else begin
                oa_nxt = sh.ovf;
                sa_nxt = sa_r | sh.sat;
              end
            end
            left_shift_op: begin
              res_w = {opnd_a[DATA_W-2:0], 1'b0};
              c_nxt = opnd_a[DATA_W-1];
              ov_nxt = opnd_a[DATA_W-1] ^ opnd_a[DATA_W-2];
              n_nxt = res_w[DATA_W-1];
              z_nxt = (res_w == '0);
            end
            left_shift_multi_op: begin
              // Amounts with bit 4 set empty the word; bits above 4 are ignored
              res_w = opb_w[4] ? '0 : opnd_a << opb_w[3:0];
              n_nxt = res_w[DATA_W-1];
              z_nxt = (res_w == '0);
            end
            sub_with_borrow_op, rev_sub_with_borrow_op: begin
              res_w = diff_w[DATA_W-1:0];
              c_nxt = diff_w[DATA_W];
              dc_nxt = nib_w[4];
              ov_nxt = (mn_w[DATA_W-1] ^ sb_w[DATA_W-1])
                       & (mn_w[DATA_W-1] ^ res_w[DATA_W-1]);
              n_nxt = res_w[DATA_W-1];
              z_nxt = (res_w == '0);
            end
            default: begin
              // Table access: reads address by a, writes by b
              done_nxt = 1'b0;
              res_valid_nxt = 1'b0;
              state_nxt = ST_TABLE;
              tbl_op_nxt = op_code;
              tbl_addr_nxt = (op_code == table_read_high_op ||
                              op_code == table_read_low_op)
                             ? {tbl_page, opnd_a} : {tbl_page, opb_w};
              tbl_wdata_nxt = {opnd_a[7:0], opnd_a};
            end
          endcase
          res_data_nxt = res_w;
        end
      end
      ST_TABLE: begin
        // Second cycle: memory answers combinationally this cycle
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
        res_valid_nxt = tbl_read_w;
        if (tbl_op_r == table_read_high_op) begin
          res_data_nxt = {8'h00, pm_rdata[PM_W-1:DATA_W]};
        end else if (tbl_op_r == table_read_low_op) begin
          res_data_nxt = pm_rdata[DATA_W-1:0];
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      tbl_op_r <= table_read_low_op;
      tbl_addr_r <= '0;
      tbl_wdata_r <= '0;
      res_data_r <= '0;
      res_valid_r <= 1'b0;
      done_r <= 1'b0;
      acc_wr_r <= 1'b0;
      acc_sel_r <= 1'b0;
      acc_res_r <= '0;
      c_r <= FLAG_RESET;
      dc_r <= FLAG_RESET;
      n_r <= FLAG_RESET;
      ov_r <= FLAG_RESET;
      z_r <= FLAG_RESET;
      oa_r <= FLAG_RESET;
      ob_r <= FLAG_RESET;
      sa_r <= FLAG_RESET;
      sb_r <= FLAG_RESET;
    end else begin
      state_r <= state_nxt;
      tbl_op_r <= tbl_op_nxt;
      tbl_addr_r <= tbl_addr_nxt;
      tbl_wdata_r <= tbl_wdata_nxt;
      res_data_r <= res_data_nxt;
      res_valid_r <= res_valid_nxt;
      done_r <= done_nxt;
      acc_wr_r <= acc_wr_nxt;
      acc_sel_r <= acc_sel_nxt;
      acc_res_r <= acc_res_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      n_r <= n_nxt;
      ov_r <= ov_nxt;
      z_r <= z_nxt;
      oa_r <= oa_nxt;
      ob_r <= ob_nxt;
      sa_r <= sa_nxt;
      sb_r <= sb_nxt;
    end
  end

  assign tbl_read_w = (tbl_op_r == table_read_high_op) ||
                      (tbl_op_r == table_read_low_op);
  assign pm_addr = tbl_addr_r;
  assign pm_wdata = tbl_wdata_r;
  assign pm_rd = (state_r == ST_TABLE) && tbl_read_w;
  assign pm_wr_hi = (state_r == ST_TABLE) &&
                    (tbl_op_r == table_write_high_op);
  assign pm_wr_lo = (state_r == ST_TABLE) &&
                    (tbl_op_r == table_write_low_op);
  assign op_done = done_r;
  assign res_valid = res_valid_r;
  assign res_data = res_data_r;
  assign acc_wr = acc_wr_r;
  assign acc_wr_sel = acc_sel_r;
  assign acc_res = acc_res_r;
  assign flag_c = c_r;
  assign digit_carry_flag = dc_r;
  assign flag_n = n_r;
  assign signed_overflow_flag = ov_r;
  assign flag_z = z_r;
  assign accum_a_overflow_flag = oa_r;
  assign accum_b_overflow_flag = ob_r;
  assign accum_any_overflow_flag = oa_r | ob_r;
  assign accum_a_saturate_flag = sa_r;
  assign accum_b_saturate_flag = sb_r;
  assign accum_any_saturate_flag = sa_r | sb_r;

  // Checks on the executed behaviour
  logic [DATA_W-1:0] sub_with_borrow_op_ref_w, rev_sub_with_borrow_op_ref_w;
  assign sub_with_borrow_op_ref_w = opnd_a - opb_w - {{(DATA_W-1){1'b0}}, ~c_r};
  assign rev_sub_with_borrow_op_ref_w = opb_w - opnd_a - {{(DATA_W-1){1'b0}}, ~c_r};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence table_issue;
    fire_w && (op_code inside {table_read_high_op, table_read_low_op,
                               table_write_high_op, table_write_low_op});
  endsequence
  sequence table_finish;
    !op_ready && !op_done ##1 op_done && op_ready;
  endsequence

  chk_rotate_right_nocarry_op_result: assert property (
    fire_w && op_code == rotate_right_nocarry_op |=> res_valid &&
    res_data == {$past(opnd_a[0]), $past(opnd_a[DATA_W-1:1])} &&
    flag_c == $past(flag_c) && signed_overflow_flag == $past(ov_r))
    else $error("rotate result or flags wrong");
  chk_sac_no_flags: assert property (
    fire_w && op_code inside {accum_store_op, accum_store_rounded_op}
    |=> res_valid && flag_c == $past(c_r) && flag_z == $past(z_r) &&
    flag_n == $past(n_r))
    else $error("accumulator store changed a flag");
  chk_se_flags: assert property (
    fire_w && op_code == sign_extend_op |=> op_done &&
    res_data[DATA_W-1:8] == {8{res_data[7]}} && flag_c == !flag_n)
    else $error("sign extend wrong");
  chk_accum_arith_shift_op_write: assert property (
    fire_w && op_code == accum_arith_shift_op |=> acc_wr && !res_valid &&
    acc_wr_sel == $past(acc_sel) &&
    (accum_a_saturate_flag || !$past(sa_r) || $past(acc_sel)) &&
    (accum_b_saturate_flag || !$past(sb_r) || !$past(acc_sel)))
    else $error("accumulator shift write wrong");
  chk_sl_carry: assert property (
    fire_w && op_code == left_shift_op |=> flag_c == $past(opnd_a[15])
    && res_data == {$past(opnd_a[14:0]), 1'b0})
    else $error("left shift carry wrong");
  chk_sub_with_borrow_op_value: assert property (
    fire_w && op_code == sub_with_borrow_op |=>
    res_data == $past(sub_with_borrow_op_ref_w))
    else $error("subtract with borrow value wrong");
  chk_rev_sub_with_borrow_op_value: assert property (
    fire_w && op_code == rev_sub_with_borrow_op |=>
    res_data == $past(rev_sub_with_borrow_op_ref_w))
    else $error("reverse subtract with borrow value wrong");
  chk_table_two_cycles: assert property (
    table_issue |=> table_finish)
    else $error("table operation not two cycles");
  chk_rdh_byte: assert property (
    fire_w && op_code == table_read_high_op |=> pm_rd ##1
    res_valid && res_data == {8'h00, $past(pm_rdata[PM_W-1:DATA_W])})
    else $error("table read high data wrong");
  chk_wth_strobe: assert property (
    fire_w && op_code == table_write_high_op |=> pm_wr_hi && !pm_wr_lo &&
    pm_wdata[PM_W-1:DATA_W] == $past(opnd_a[7:0]) ##1 !res_valid)
    else $error("table write high wrong");
  chk_wtl_strobe: assert property (
    fire_w && op_code == table_write_low_op |=> pm_wr_lo && !pm_wr_hi &&
    pm_wdata[DATA_W-1:0] == $past(opnd_a))
    else $error("table write low wrong");
  chk_ze_flags: assert property (
    fire_w && op_code == zero_extend_op |=> flag_c && !flag_n &&
    res_data[DATA_W-1:8] == 8'h00 && flag_z == (res_data == '0))
    else $error("zero extend wrong");
  chk_table_keep_flags: assert property (
    table_issue |=> ##1 flag_c == $past(c_r, 2) && flag_z == $past(z_r, 2))
    else $error("table operation changed a flag");
endmodule

// ===== pm_model.sv
// Program memory model answering table reads and writes
`timescale 1ns/1ps
module pm_model (
  // Clock
  input wire logic sys_clk,
  // Table access
  input wire logic [exec_pkg::PM_W-1:0] pm_addr,
  input wire logic pm_rd,
  input wire logic pm_wr_hi,
  input wire logic pm_wr_lo,
  input wire logic [exec_pkg::PM_W-1:0] pm_wdata,
  output logic [exec_pkg::PM_W-1:0] pm_rdata
);
  import exec_pkg::*;
  logic [PM_W-1:0] mem [int];
  logic [PM_W-1:0] last_r = 24'h000000;
  // Off a read the bus shows the inverse of the last word, never a stale copy
  always @* begin
    if (!pm_rd)
      pm_rdata = ~last_r;
    else if (mem.exists(int'(pm_addr)))
      pm_rdata = mem[int'(pm_addr)];
    else
      pm_rdata = pm_addr ^ 24'h5A5A5A;
  end
  always @(posedge sys_clk) begin
    if (pm_rd)
      last_r <= pm_rdata;
    if (pm_wr_hi)
      mem[int'(pm_addr)][23:16] <= pm_wdata[23:16];
    if (pm_wr_lo)
      mem[int'(pm_addr)][15:0] <= pm_wdata[15:0];
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the execution subset
`timescale 1ns/1ps
`define CHK(g, e) chk(64'(g), 64'(e));
module tb_top;
  import exec_pkg::*;
  logic sys_clk, sys_rst = 1'b1, op_valid = 1'b0, op_use_lit = 1'b0;
  logic acc_sel = 1'b0, sat_enable = 1'b0;
  op_t op_code = rotate_right_nocarry_op;
  logic [DATA_W-1:0] opnd_a = 16'h0000, opnd_b = 16'h0000, res_data;
  logic [LIT_W-1:0] op_lit = 10'h000;
  logic [ACC_W-1:0] acc_a = 40'h0, acc_b = 40'h0, acc_res;
  logic [PAGE_W-1:0] tbl_page = 8'h00;
  logic op_ready, op_done, res_valid, acc_wr, acc_wr_sel;
  logic [PM_W-1:0] pm_addr, pm_wdata, pm_rdata;
  logic pm_rd, pm_wr_hi, pm_wr_lo, fc, fdc, fn, fov, fz;
  logic foa, fob, foab, fsa, fsb, fsab;
  // Reference flags and memory image
  logic mc = 0, mdc = 0, mn = 0, mov = 0, mz = 0;
  logic moa = 0, mob = 0, msa = 0, msb = 0;
  logic [PM_W-1:0] exp_mem [int];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  op_t alu [7] = '{rotate_right_nocarry_op, sign_extend_op, zero_extend_op,
    left_shift_op, left_shift_multi_op, sub_with_borrow_op,
    rev_sub_with_borrow_op};

  instr_exec_subset DUT (.sys_clk, .sys_rst, .op_valid, .op_ready, .op_code,
    .opnd_a, .opnd_b, .op_use_lit, .op_lit, .acc_sel, .acc_a, .acc_b,
    .sat_enable, .tbl_page, .op_done, .res_valid, .res_data, .acc_wr,
    .acc_wr_sel, .acc_res, .pm_addr, .pm_rd, .pm_wr_hi, .pm_wr_lo,
    .pm_wdata, .pm_rdata, .flag_c(fc), .digit_carry_flag(fdc), .flag_n(fn),
    .signed_overflow_flag(fov), .flag_z(fz), .accum_a_overflow_flag(foa),
    .accum_b_overflow_flag(fob), .accum_any_overflow_flag(foab),
    .accum_a_saturate_flag(fsa), .accum_b_saturate_flag(fsb),
    .accum_any_saturate_flag(fsab));
  pm_model mem_far (.sys_clk, .pm_addr, .pm_rd, .pm_wr_hi, .pm_wr_lo,
    .pm_wdata, .pm_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, e);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic model(input op_t op, input logic [15:0] a, b,
      input logic ul, input logic [9:0] lit, output logic [15:0] r,
      output logic [39:0] ac);
    logic [15:0] o;
    logic [16:0] s;
    logic [4:0] d;
    logic ovf;
    longint v;
    int sh;
    o = ul ? {6'h00, lit} : b;
    r = 16'h0000;
    ac = 40'h0;
    v = acc_sel ? {{24{acc_b[39]}}, acc_b} : {{24{acc_a[39]}}, acc_a};
    case (op)
      rotate_right_nocarry_op: r = {a[0], a[15:1]};
      sign_extend_op: begin
        r = {{8{a[7]}}, a[7:0]};
        mc = ~a[7];
      end
      zero_extend_op: begin
        r = {8'h00, a[7:0]};
        mc = 1'b1;
      end
      left_shift_op: begin
        r = {a[14:0], 1'b0};
        mc = a[15];
        mov = a[15] ^ a[14];
      end
      left_shift_multi_op: r = o[4] ? 16'h0000 : a << o[3:0];
      sub_with_borrow_op, rev_sub_with_borrow_op: begin
        if (op == rev_sub_with_borrow_op)
          {a, o} = {o, a};
        s = {1'b0, a} + {1'b0, ~o} + 17'(mc);
        d = {1'b0, a[3:0]} + {1'b0, ~o[3:0]} + 5'(mc);
        r = s[15:0];
        mc = s[16];
        mdc = d[4];
        mov = (a[15] != o[15]) && (r[15] != a[15]);
      end
      table_read_high_op: r = {8'h00, exp_mem[int'({tbl_page, a})][23:16]};
      table_read_low_op: r = exp_mem[int'({tbl_page, a})][15:0];
      table_write_high_op: exp_mem[int'({tbl_page, b})][23:16] = a[7:0];
      table_write_low_op: exp_mem[int'({tbl_page, b})][15:0] = a;
      accum_store_op, accum_store_rounded_op: begin
        sh = $signed(lit[3:0]);
        v = (sh < 0) ? v <<< -sh : v >>> sh;
        if (op == accum_store_rounded_op)
          v += 32768;
        r = v[31:16];
      end
      accum_arith_shift_op: begin
        sh = $signed(o[5:0]);
        v = (sh < 0) ? v <<< -sh : v >>> sh;
        ac = v[39:0];
        ovf = !(v[39:31] == 9'h000 || v[39:31] == 9'h1FF);
        if (sat_enable && ovf) begin
          ac = (v < 0) ? SAT_NEG : SAT_POS;
          if (acc_sel) msb = 1'b1; else msa = 1'b1;
        end
        if (acc_sel) mob = ovf; else moa = ovf;
      end
      default: r = 16'h0000;
    endcase
    if (op inside {alu}) begin
      mn = r[15];
      mz = (r == 16'h0000);
    end
  endtask

  // Issue one request; holds it until taken, then checks every result
  task automatic run(input op_t op, input logic [15:0] a, b,
      input logic ul, input logic [9:0] lit);
    logic [15:0] er;
    logic [39:0] ea;
    logic rv;
    int n;
    op_code = op;
    opnd_a = a;
    opnd_b = b;
    op_use_lit = ul;
    op_lit = lit;
    op_valid = 1'b1;
    n = 0;
    while (op_ready !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    if (op >= table_read_high_op && op <= table_write_low_op) begin
      op_valid = 1'b0;
      `CHK({op_ready, op_done, pm_rd, pm_wr_hi, pm_wr_lo, pm_addr}, {2'b00, op < table_write_high_op, op == table_write_high_op, op == table_write_low_op, tbl_page, op < table_write_high_op ? a : b})
      if (op >= table_write_high_op) `CHK(pm_wdata, {a[7:0], a})
      @(posedge sys_clk);
      #1;
    end
    model(op, a, b, ul, lit, er, ea);
    rv = !(op inside {accum_arith_shift_op, table_write_high_op,
                      table_write_low_op});
    `CHK({op_done, res_valid, acc_wr}, {1'b1, rv, !rv && op < table_read_high_op})
    if (rv) `CHK(res_data, er)
    if (!rv && op < table_read_high_op) `CHK({acc_wr_sel, acc_res}, {acc_sel, ea})
    `CHK({fc, fdc, fn, fov, fz}, {mc, mdc, mn, mov, mz})
    `CHK({foa, fob, foab, fsa, fsb, fsab}, {moa, mob, moa | mob, msa, msb, msa | msb})
  endtask

  initial begin
    logic [31:0] r32;
    logic [15:0] ad, w;
    void'($urandom(32'h0F927211));
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    `CHK({op_ready, op_done, res_data, fc, fdc, fn, fov, fz, fsab}, 24'h800000)
    for (int i = 0; i < 60; i++)
      run(alu[$urandom_range(6)], 16'($urandom), 16'($urandom),
          1'($urandom), 10'($urandom));
    run(sub_with_borrow_op, 16'h8000, 16'h0001, 1'b0, 10'h000);
    run(rev_sub_with_borrow_op, 16'h0001, 16'h0000, 1'b1, 10'h3FF);
    run(left_shift_op, 16'h4000, 16'h0000, 1'b0, 10'h000);
    run(zero_extend_op, 16'hFF00, 16'h0000, 1'b0, 10'h000);
    $display("test alu done");
    for (int i = 0; i < 16; i++) begin
      r32 = $urandom;
      acc_a = {{8{r32[31]}}, r32};
      acc_b = {{8{r32[30]}}, r32[30:0], 1'b1};
      acc_sel = i[0];
      run(i[1] ? accum_store_rounded_op : accum_store_op, 16'h0000,
          16'h0000, 1'b0, 10'(i % 8 - 2));
    end
    $display("test store done");
    for (int i = 0; i < 16; i++) begin
      r32 = $urandom;
      acc_a = {{8{r32[31]}}, r32};
      acc_b = {{8{r32[31]}}, ~r32};
      acc_sel = i[0];
      run(accum_arith_shift_op, 16'h0000, 16'(i - 8), i[1], 10'(7 - i));
    end
    sat_enable = 1'b1;
    acc_a = 40'h0040000000;
    acc_b = 40'hFFA0000000;
    for (int i = 0; i < 2; i++) begin
      acc_sel = i[0];
      run(accum_arith_shift_op, 16'h0000, 16'h0000, 1'b1, 10'h03E);
    end
    $display("test accumulator shift done");
    for (int i = 0; i < 4; i++) begin
      tbl_page = 8'($urandom);
      ad = 16'($urandom);
      w = 16'($urandom);
      run(table_write_low_op, w, ad, 1'b0, 10'h000);
      run(table_write_high_op, ~w, ad, 1'b0, 10'h000);
      run(rotate_right_nocarry_op, w, ad, 1'b0, 10'h000);
      run(table_read_low_op, ad, w, 1'b0, 10'h000);
      run(table_read_high_op, ad, w, 1'b0, 10'h000);
      run(sign_extend_op, w, ad, 1'b0, 10'h000);
    end
    $display("test table done");
    op_valid = 1'b0;
    @(posedge sys_clk);
    wrap_up();
  end
endmodule
